// File: dv/tb_radio_status_io_registers.sv
`timescale 1ns/100ps
`default_nettype none
module tb_radio_status_io_registers;
  import radio_status_io_pkg::*;
  // ****************
  // bench signals
  // ****************
  localparam logic [7:0] REV = 8'h5A; // arbitrary value
  logic pclk, presetn, psel, penable, pwrite, fsk, push, pop, sup, err;
  logic pready, pslverr, fapp, xtal, extref, bmax, sdet;
  logic [8:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, olev;
  logic [7:0] pbyte, popb, temp;
  logic [5:0] gp;
  logic [23:0] cfw, afreq;
  logic [15:0] rint;
  logic [19:0] rdiv;
  logic [2:0] bsel;
  op_mode_e mode;
  radio_evt_s ev;
  int failures = 0;
  int num_checks = 0;
  radio_status_io_registers #(.REVISION(REV)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_mode(mode), .radio_evt(ev), .fsk_mode(fsk), .push_stb(push),
    .push_byte(pbyte), .pop_stb(pop), .pop_byte(popb), .supply_below_async(sup),
    .temp_reading(temp), .output_level(olev), .rate_div_integer(rint),
    .carrier_freq_word(cfw), .gp_pin(gp), .freq_apply(fapp), .applied_freq(afreq),
    .xtal_drive_en(xtal), .ext_ref_accept(extref), .amp_boost_select(bsel),
    .boost_max(bmax), .rate_divisor(rdiv), .supply_detector_on(sdet));
  // ****************
  // shared tasks
  // ****************
  task finish_test;
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // apb transfer, request held until pready is sampled high
  task apb(input logic w, input logic [6:0] i, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk) penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      finish_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task rdc(input string nm, input logic [6:0] i, input logic [7:0] e);
    apb(0, i, 8'h00);
    chk(nm, rd, {24'h0, e});
  endtask : rdc
  // push_stb held for n edges gives n stored bytes
  task push_n(input int n);
    @(posedge pclk) push <= 1;
    repeat (n) @(posedge pclk);
    push <= 0;
  endtask : push_n
  // ****************
  // scenarios
  // ****************
  task t_reset;
    rdc("map1", IDX_MAP1, 8'h00);
    rdc("map2", IDX_MAP2, 8'h00);
    rdc("retune", IDX_RETUNE, 8'h2D);
    rdc("amp", IDX_AMP, 8'h84);
    rdc("frac", IDX_FRAC, 8'h00);
    chk("bsel", bsel, 3'h4);
    chk("xtal", {extref, xtal}, 2'b01);
    apb(1, IDX_REV, 8'h00);
    rdc("rev", IDX_REV, REV);
    rdc("unmapped", 7'h7F, 8'h00);
    chk("slverr", err, 1'b1);
  endtask : t_reset
  task t_buffer;
    push_n(15);
    rdc("lvl15", IDX_IRQ2, 8'h00);
    push_n(1);
    rdc("lvl16", IDX_IRQ2, 8'h20);
    push_n(50);
    rdc("full", IDX_IRQ2, 8'hA0);
    push_n(1);
    rdc("ovr", IDX_IRQ2, 8'hB0);
    apb(1, IDX_IRQ2, 8'h10);
    rdc("flush", IDX_IRQ2, 8'h40);
    apb(1, IDX_IRQ2, 8'hEE);
    rdc("ro", IDX_IRQ2, 8'h40);
    apb(1, IDX_BUF_DATA, 8'h77);
    rdc("data", IDX_BUF_DATA, 8'h77);
    rdc("pop0", IDX_BUF_DATA, 8'hC3); // empty read shows a stale slot from the earlier fill
    rdc("ovr2", IDX_IRQ2, 8'h50);
    apb(1, IDX_IRQ2, 8'h10);
    @(posedge pclk) mode <= MODE_SLEEP;
    @(posedge pclk) pop <= 1;
    @(posedge pclk) pop <= 0;
    rdc("sleep", IDX_IRQ2, 8'h40);
    mode <= MODE_STANDBY;
  endtask : t_buffer
  task t_pins;
    ev.signal_level_event <= 1;
    apb(1, IDX_MAP1, 8'h6C);
    repeat (2) @(posedge pclk);
    chk("gp_a", gp[3:0], 4'b0110);
    apb(1, IDX_MAP2, 8'hF1);
    repeat (2) @(posedge pclk);
    chk("gp_b", gp, 6'b000010);
    ev.sync_lead_event <= 1;
    repeat (2) @(posedge pclk);
    chk("gp_c", gp, 6'b110110);
  endtask : t_pins
  task t_retune;
    cfw <= 24'h123456;
    apb(1, IDX_RETUNE, 8'hAD);
    @(posedge pclk) ev.freq_lsb_written <= 1;
    @(posedge pclk) ev.freq_lsb_written <= 0;
    @(negedge pclk) chk("hop", {fapp, afreq}, {1'b1, 24'h123456});
    cfw <= 24'h0ABCDE;
    apb(1, IDX_RETUNE, 8'h2D);
    mode <= MODE_SYNTH_TX;
    @(posedge pclk);
    @(negedge pclk) chk("synth", {fapp, afreq}, {1'b1, 24'h0ABCDE});
    @(posedge pclk) mode <= MODE_STANDBY;
    cfw <= 24'h654321;
    @(posedge pclk) mode <= MODE_SYNTH_RX;
    @(posedge pclk);
    @(negedge pclk) chk("synth_rx", {fapp, afreq}, {1'b1, 24'h654321});
    @(posedge pclk) mode <= MODE_STANDBY;
  endtask : t_retune
  task t_supply;
    sup <= 1;
    repeat (6) @(posedge pclk);
    rdc("sup_off", IDX_IRQ2, 8'h40);
    apb(1, IDX_SUPPLY_CFG, 8'h0A);
    repeat (6) @(posedge pclk);
    chk("sdet", sdet, 1'b1);
    sup <= 0;
    repeat (6) @(posedge pclk);
    rdc("sticky", IDX_IRQ2, 8'h41);
    apb(1, IDX_IRQ2, 8'h01);
    rdc("w1c", IDX_IRQ2, 8'h40);
  endtask : t_supply
  task t_misc;
    apb(1, IDX_AMP, 8'h87);
    apb(1, IDX_REFSEL, 8'h19);
    apb(1, IDX_FRAC, 8'hF5);
    rdc("frac_rb", IDX_FRAC, 8'h05);
    pstrb <= 4'hE;
    apb(1, IDX_FRAC, 8'h0A);
    pstrb <= 4'hF;
    rdc("strb", IDX_FRAC, 8'h05);
    chk("boost", {bmax, bsel}, 4'hF);
    chk("ref", {extref, xtal}, 2'b10);
    chk("div", rdiv, 20'h12345);
    fsk <= 0;
    repeat (2) @(posedge pclk);
    chk("div_ook", rdiv, 20'h12340);
    @(posedge pclk) ev.cal_done <= 1;
    @(posedge pclk) ev.cal_done <= 0;
    rdc("caltemp", IDX_LAST_TEMP, 8'hD8);
  endtask : t_misc
  task t_frame;
    @(posedge pclk) mode <= MODE_TX;
    @(posedge pclk) ev.frame_done <= 1;
    @(posedge pclk) ev.frame_done <= 0;
    rdc("sent", IDX_IRQ2, 8'h48);
    mode <= MODE_RX;
    rdc("left", IDX_IRQ2, 8'h40);
    push_n(1);
    @(posedge pclk) ev.last_byte_rx <= 1;
    ev.check_good <= 1;
    @(posedge pclk) ev.last_byte_rx <= 0;
    rdc("ready", IDX_IRQ2, 8'h06);
    rdc("pop", IDX_BUF_DATA, 8'hC3);
    rdc("clr", IDX_IRQ2, 8'h40);
    ev.check_good <= 0;
    push_n(1);
    @(posedge pclk) ev.last_byte_rx <= 1;
    @(posedge pclk) ev.last_byte_rx <= 0;
    rdc("bad", IDX_IRQ2, 8'h00);
    apb(1, IDX_CHECK_CFG, 8'h18);
    @(posedge pclk) ev.last_byte_rx <= 1;
    @(posedge pclk) ev.last_byte_rx <= 0;
    rdc("keep", IDX_IRQ2, 8'h04);
    @(posedge pclk) pop <= 1;
    @(posedge pclk) pop <= 0;
    @(negedge pclk) chk("popb", popb, 8'hC3);
  endtask : t_frame
  // ****************
  // clock, reset, sequence
  // ****************
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    pstrb = 4'hF; mode = MODE_STANDBY; ev = '0; fsk = 1; push = 0; pbyte = 8'hC3;
    pop = 0; sup = 0; temp = 8'hD8; olev = 4'hF; rint = 16'h1234; cfw = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_buffer;
    t_pins;
    t_retune;
    t_supply;
    t_misc;
    t_frame;
    finish_test;
  end
endmodule : tb_radio_status_io_registers
`default_nettype wire

// File: src/radio_status_io_pkg.sv
`default_nettype none
// ****************************************************************
// shared constants and types
// ****************************************************************
package radio_status_io_pkg;
  // apb address width, data buffer depth
  localparam int ADDR_W = 9;
  localparam int BUF_DEPTH = 66;
  // register word indices (byte address is four times the index)
  localparam logic [6:0] IDX_BUF_DATA = 7'h00;
  localparam logic [6:0] IDX_CHECK_CFG = 7'h30;
  localparam logic [6:0] IDX_BUF_CFG = 7'h35;
  localparam logic [6:0] IDX_SUPPLY_CFG = 7'h3D;
  localparam logic [6:0] IDX_IRQ2 = 7'h3F;
  localparam logic [6:0] IDX_MAP1 = 7'h40;
  localparam logic [6:0] IDX_MAP2 = 7'h41;
  localparam logic [6:0] IDX_REV = 7'h42;
  localparam logic [6:0] IDX_RETUNE = 7'h44;
  localparam logic [6:0] IDX_REFSEL = 7'h4B;
  localparam logic [6:0] IDX_AMP = 7'h4D;
  localparam logic [6:0] IDX_LAST_TEMP = 7'h5B;
  localparam logic [6:0] IDX_FRAC = 7'h5D;
  // second flag register bit positions
  localparam int B_FULL = 7;
  localparam int B_EMPTY = 6;
  localparam int B_LEVEL = 5;
  localparam int B_OVERRUN = 4;
  localparam int B_SENT = 3;
  localparam int B_READY = 2;
  localparam int B_CHECK = 1;
  localparam int B_SUPPLY = 0;
  // control bit positions
  localparam int B_RETUNE_EN = 7;
  localparam int B_EXT_REF = 4;
  localparam int B_EVT_CHOICE = 0;
  localparam int B_CHECK_ON = 4;
  localparam int B_CHECK_KEEP = 3;
  localparam int B_SUPPLY_EN = 3;
  // reset values
  localparam logic [7:0] MAP1_RST = 8'h00;
  localparam logic [7:0] MAP2_RST = 8'h00;
  localparam logic [7:0] RETUNE_RST = 8'h2D;
  localparam logic [7:0] REFSEL_RST = 8'h09;
  localparam logic [7:0] AMP_RST = 8'h84;
  localparam logic [7:0] LAST_TEMP_RST = 8'h00;
  localparam logic [3:0] FRAC_RST = 4'h0;
  localparam logic [6:0] BUF_CFG_RST = 7'h0F;
  localparam logic [7:0] CHECK_CFG_RST = 8'h10;
  localparam logic [7:0] SUPPLY_CFG_RST = 8'h02;
  // top boost code and top output level
  localparam logic [2:0] AMP_MAX = 3'h7;
  localparam logic [3:0] LEVEL_MAX = 4'hF;
  // pin event select codes
  localparam logic [1:0] SEL_FRAME = 2'h0;
  localparam logic [1:0] SEL_LEVEL = 2'h1;
  localparam logic [1:0] SEL_EMPTY = 2'h2;
  localparam logic [1:0] SEL_CHOSEN = 2'h3;
  // operating modes
  typedef enum logic [2:0] {
    MODE_SLEEP = 3'h0,
    MODE_STANDBY = 3'h1,
    MODE_SYNTH_TX = 3'h2,
    MODE_TX = 3'h3,
    MODE_SYNTH_RX = 3'h4,
    MODE_RX = 3'h5
  } op_mode_e;
  // single-cycle events and levels from the radio datapath
  typedef struct packed {
    logic frame_done;
    logic last_byte_rx;
    logic check_good;
    logic cal_done;
    logic signal_level_event;
    logic sync_lead_event;
    logic freq_lsb_written;
  } radio_evt_s;
endpackage : radio_status_io_pkg
`default_nettype wire

// File: src/radio_status_io_registers.sv
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module radio_status_io_registers
  import radio_status_io_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'hA5, // arbitrary value
  parameter int DEPTH = BUF_DEPTH
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // radio datapath side
  input wire op_mode_e op_mode,
  input wire radio_evt_s radio_evt,
  input wire logic fsk_mode,
  input wire logic push_stb,
  input wire logic [7:0] push_byte,
  input wire logic pop_stb,
  output logic [7:0] pop_byte,
  // analogue status and measurements
  input wire logic supply_below_async,
  input wire logic [7:0] temp_reading,
  input wire logic [3:0] output_level,
  input wire logic [15:0] rate_div_integer,
  input wire logic [23:0] carrier_freq_word,
  // controls to the radio
  output logic [5:0] gp_pin,
  output logic freq_apply,
  output logic [23:0] applied_freq,
  output logic xtal_drive_en,
  output logic ext_ref_accept,
  output logic [2:0] amp_boost_select,
  output logic boost_max,
  output logic [19:0] rate_divisor,
  output logic supply_detector_on
);

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic pready_r; // one wait state per access
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [6:0] idx; // word index
  logic mapped; // address hits a register
  logic wr_fire; // write takes effect
  logic rd_fire; // read completes
  logic [7:0] rd_byte; // read mux
  logic wr_lane; // low byte lane enabled

  assign idx = paddr[ADDR_W-1:2];
  assign wr_lane = pstrb[0];
  assign wr_fire = psel & penable & pready_r & pwrite & mapped & wr_lane;
  assign rd_fire = psel & penable & pready_r & ~pwrite & mapped;

  // address map check
  always_comb begin
    case (idx)
      IDX_BUF_DATA, IDX_CHECK_CFG, IDX_BUF_CFG, IDX_SUPPLY_CFG, IDX_IRQ2,
      IDX_MAP1, IDX_MAP2, IDX_REV, IDX_RETUNE, IDX_REFSEL, IDX_AMP,
      IDX_LAST_TEMP, IDX_FRAC: mapped = (paddr[1:0] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [7:0] map1_r; // pins 0-3 selects
  logic [7:0] map2_r; // pins 4-5 selects, choice bit
  logic [7:0] retune_r;
  logic [7:0] refsel_r;
  logic [7:0] amp_r;
  logic [7:0] last_temp_r;
  logic [3:0] frac_r;
  logic [6:0] thresh_r; // buffer level threshold
  logic [7:0] check_cfg_r;
  logic [7:0] supply_cfg_r;

  // plain read/write registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map1_r <= MAP1_RST;
      map2_r <= MAP2_RST;
      retune_r <= RETUNE_RST;
      refsel_r <= REFSEL_RST;
      amp_r <= AMP_RST;
      frac_r <= FRAC_RST;
      thresh_r <= BUF_CFG_RST;
      check_cfg_r <= CHECK_CFG_RST;
      supply_cfg_r <= SUPPLY_CFG_RST;
    end else if (wr_fire) begin
      case (idx)
        IDX_MAP1: map1_r <= pwdata[7:0];
        IDX_MAP2: map2_r <= pwdata[7:0];
        IDX_RETUNE: retune_r <= pwdata[7:0];
        IDX_REFSEL: refsel_r <= pwdata[7:0];
        IDX_AMP: amp_r <= pwdata[7:0];
        IDX_FRAC: frac_r <= pwdata[3:0]; // upper nibble reads zero
        IDX_BUF_CFG: thresh_r <= pwdata[6:0];
        IDX_CHECK_CFG: check_cfg_r <= pwdata[7:0];
        IDX_SUPPLY_CFG: supply_cfg_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // last calibration temperature, capture beats software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_temp_r <= LAST_TEMP_RST;
    end else if (radio_evt.cal_done) begin
      last_temp_r <= temp_reading;
    end else if (wr_fire && idx == IDX_LAST_TEMP) begin
      last_temp_r <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // data buffer
  // ****************************************************************
  logic [7:0] mem [DEPTH];
  logic [6:0] wptr_r;
  logic [6:0] rptr_r;
  logic [6:0] count_r;
  logic full; // buffer at capacity
  logic empty; // buffer holds nothing
  logic push_req;
  logic pop_req;
  logic do_push;
  logic do_pop;
  logic flush; // software write-one to overrun
  logic empty_evt; // buffer just became empty
  logic [7:0] push_data;
  logic [7:0] pop_byte_r;

  assign full = (count_r == 7'(DEPTH));
  assign empty = (count_r == 7'h00);
  assign push_req = push_stb | (wr_fire & (idx == IDX_BUF_DATA));
  assign pop_req = pop_stb | (rd_fire & (idx == IDX_BUF_DATA));
  assign push_data = push_stb ? push_byte : pwdata[7:0];
  assign do_push = push_req & ~full;
  assign do_pop = pop_req & ~empty;
  assign flush = wr_fire & (idx == IDX_IRQ2) & pwdata[B_OVERRUN];
  assign empty_evt = flush | (do_pop & ~do_push & (count_r == 7'h01));

  // storage array
  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wptr_r] <= push_data;
    end
  end

  // pointers and count, flush empties at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_r <= 7'h00;
      rptr_r <= 7'h00;
      count_r <= 7'h00;
    end else if (flush) begin
      wptr_r <= 7'h00;
      rptr_r <= 7'h00;
      count_r <= 7'h00;
    end else begin
      if (do_push) begin
        wptr_r <= (wptr_r == 7'(DEPTH - 1)) ? 7'h00 : wptr_r + 7'h01;
      end
      if (do_pop) begin
        rptr_r <= (rptr_r == 7'(DEPTH - 1)) ? 7'h00 : rptr_r + 7'h01;
      end
      if (do_push && !do_pop) begin
        count_r <= count_r + 7'h01;
      end else if (do_pop && !do_push) begin
        count_r <= count_r - 7'h01;
      end
    end
  end

  // popped byte for the datapath
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pop_byte_r <= 8'h00;
    end else if (do_pop) begin
      pop_byte_r <= mem[rptr_r];
    end
  end

  // ****************************************************************
  // event flags
  // ****************************************************************
  logic overrun_r;
  logic sent_r;
  logic ready_r;
  logic check_r;
  logic supply_r;
  logic level; // count above threshold
  logic overrun_evt;
  logic ready_ok; // check gate for payload ready
  logic [1:0] supply_sync_r; // two-stage synchroniser
  logic in_rx;

  assign level = (count_r > thresh_r);
  assign in_rx = (op_mode == MODE_RX);
  // overflow or underflow outside sleep
  assign overrun_evt = ((push_req & full) | (pop_req & empty)) & (op_mode != MODE_SLEEP);
  assign ready_ok = ~check_cfg_r[B_CHECK_ON] | check_cfg_r[B_CHECK_KEEP] | radio_evt.check_good;

  // overrun: set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_r <= 1'b0;
    end else if (overrun_evt) begin
      overrun_r <= 1'b1;
    end else if (flush) begin
      overrun_r <= 1'b0;
    end
  end

  // frame sent only while transmitting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sent_r <= 1'b0;
    end else if (op_mode != MODE_TX) begin
      sent_r <= 1'b0;
    end else if (radio_evt.frame_done) begin
      sent_r <= 1'b1;
    end
  end

  // payload ready, set wins over empty clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_r <= 1'b0;
    end else if (in_rx && radio_evt.last_byte_rx && ready_ok) begin
      ready_r <= 1'b1;
    end else if (empty_evt) begin
      ready_r <= 1'b0;
    end
  end

  // check pass, set wins over empty clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_r <= 1'b0;
    end else if (in_rx && radio_evt.last_byte_rx && radio_evt.check_good) begin
      check_r <= 1'b1;
    end else if (empty_evt) begin
      check_r <= 1'b0;
    end
  end

  // supply comparator crosses clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_sync_r <= 2'b00;
    end else begin
      supply_sync_r <= {supply_sync_r[0], supply_below_async};
    end
  end

  // supply low, sticky until write-one, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_r <= 1'b0;
    end else if (supply_cfg_r[B_SUPPLY_EN] && supply_sync_r[1]) begin
      supply_r <= 1'b1;
    end else if (wr_fire && idx == IDX_IRQ2 && pwdata[B_SUPPLY]) begin
      supply_r <= 1'b0;
    end
  end

  // ****************************************************************
  // read mux and apb response
  // ****************************************************************
  logic [7:0] flags2; // only overrun and supply bits are writable
  assign flags2 = {full, empty, level, overrun_r, sent_r, ready_r, check_r, supply_r};

  // read data selection
  always_comb begin
    case (idx)
      IDX_BUF_DATA: rd_byte = mem[rptr_r];
      IDX_CHECK_CFG: rd_byte = check_cfg_r;
      IDX_BUF_CFG: rd_byte = {1'b0, thresh_r};
      IDX_SUPPLY_CFG: rd_byte = supply_cfg_r;
      IDX_IRQ2: rd_byte = flags2;
      IDX_MAP1: rd_byte = map1_r;
      IDX_MAP2: rd_byte = map2_r;
      IDX_REV: rd_byte = REVISION;
      IDX_RETUNE: rd_byte = retune_r;
      IDX_REFSEL: rd_byte = refsel_r;
      IDX_AMP: rd_byte = amp_r;
      IDX_LAST_TEMP: rd_byte = last_temp_r;
      IDX_FRAC: rd_byte = {4'h0, frac_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // one wait state, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel && penable && !pready_r) begin
      pready_r <= 1'b1;
      prdata_r <= {24'h00_0000, (mapped && !pwrite) ? rd_byte : 8'h00};
      pslverr_r <= ~mapped;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // ****************************************************************
  // radio controls
  // ****************************************************************
  logic [5:0] gp_pin_r;
  logic freq_apply_r;
  logic [23:0] applied_freq_r;
  logic xtal_r;
  logic ext_r;
  logic [2:0] amp_sel_r;
  logic boost_max_r;
  logic [19:0] divisor_r;
  logic detector_r;
  op_mode_e mode_prev_r;
  logic [11:0] pin_sel; // six packed two-bit selects
  logic chosen_evt;
  logic frame_evt;
  logic synth_req; // entry into a synth mode
  logic apply_now;

  assign pin_sel = {map2_r[5:4], map2_r[7:6], map1_r[1:0], map1_r[3:2], map1_r[5:4], map1_r[7:6]};
  assign chosen_evt = map2_r[B_EVT_CHOICE] ? radio_evt.sync_lead_event : radio_evt.signal_level_event;
  assign frame_evt = in_rx ? ready_r : sent_r;
  assign synth_req = (op_mode != mode_prev_r) && (op_mode == MODE_SYNTH_TX || op_mode == MODE_SYNTH_RX);
  assign apply_now = retune_r[B_RETUNE_EN] ? radio_evt.freq_lsb_written : synth_req;

  // per-pin event routing
  for (genvar p = 0; p < 6; p++) begin : g_pin
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gp_pin_r[p] <= 1'b0;
      end else begin
        case (pin_sel[2*p +: 2])
          SEL_FRAME: gp_pin_r[p] <= frame_evt;
          SEL_LEVEL: gp_pin_r[p] <= level;
          SEL_EMPTY: gp_pin_r[p] <= empty;
          SEL_CHOSEN: gp_pin_r[p] <= chosen_evt;
          default: gp_pin_r[p] <= 1'b0;
        endcase
      end
    end
  end

  // carrier word validation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_prev_r <= MODE_SLEEP;
      freq_apply_r <= 1'b0;
      applied_freq_r <= 24'h00_0000;
    end else begin
      mode_prev_r <= op_mode;
      freq_apply_r <= apply_now;
      if (apply_now) begin
        applied_freq_r <= carrier_freq_word;
      end
    end
  end

  // reference, boost, divisor, detector enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_r <= 1'b1;
      ext_r <= 1'b0;
      amp_sel_r <= AMP_RST[2:0];
      boost_max_r <= 1'b0;
      divisor_r <= 20'h0_0000;
      detector_r <= 1'b0;
    end else begin
      xtal_r <= ~refsel_r[B_EXT_REF];
      ext_r <= refsel_r[B_EXT_REF];
      amp_sel_r <= amp_r[2:0];
      boost_max_r <= (amp_r[2:0] == AMP_MAX) && (output_level == LEVEL_MAX);
      divisor_r <= {rate_div_integer, fsk_mode ? frac_r : 4'h0};
      detector_r <= supply_cfg_r[B_SUPPLY_EN];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pop_byte = pop_byte_r;
  assign gp_pin = gp_pin_r;
  assign freq_apply = freq_apply_r;
  assign applied_freq = applied_freq_r;
  assign xtal_drive_en = xtal_r;
  assign ext_ref_accept = ext_r;
  assign amp_boost_select = amp_sel_r;
  assign boost_max = boost_max_r;
  assign rate_divisor = divisor_r;
  assign supply_detector_on = detector_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_access_start;
    psel && penable && !pready_r;
  endsequence
  sequence s_answer;
    pready_r ##1 !pready_r;
  endsequence

  apb_answer_a: assert property (s_access_start |=> s_answer) else $error("apb answer late");
  // count never passes capacity, full tracks it
  full_count_a: assert property (count_r <= 7'(DEPTH) && (flags2[B_FULL] == (count_r == 7'(DEPTH))))
    else $error("full flag wrong");
  // empty buffer means both pointers meet
  empty_count_a: assert property ((flags2[B_EMPTY] == (count_r == 7'h00)) && (!flags2[B_EMPTY] || wptr_r == rptr_r))
    else $error("empty flag wrong");
  // one byte past the threshold raises level
  level_thresh_a: assert property (count_r == thresh_r && do_push && !do_pop && !flush
    && !(wr_fire && idx == IDX_BUF_CFG) |=> flags2[B_LEVEL]) else $error("level flag wrong");
  // a last byte in the flush cycle may set ready again
  flush_empty_a: assert property (flush && !radio_evt.last_byte_rx |=> count_r == 7'h00 && !ready_r && !check_r)
    else $error("flush failed");
  overrun_set_a: assert property (overrun_evt |=> overrun_r) else $error("overrun lost");
  sent_clear_a: assert property (op_mode != MODE_TX |=> !sent_r) else $error("sent not cleared");
  ready_set_a: assert property (in_rx && radio_evt.last_byte_rx && radio_evt.check_good |=> ready_r && check_r)
    else $error("ready not set");
  supply_hold_a: assert property ($rose(supply_r) |-> $past(supply_cfg_r[B_SUPPLY_EN]))
    else $error("detector idle set");
  supply_sticky_a: assert property (supply_r && !(wr_fire && idx == IDX_IRQ2 && pwdata[B_SUPPLY]) |=> supply_r)
    else $error("supply flag dropped");
  retune_apply_a: assert property (retune_r[B_RETUNE_EN] && radio_evt.freq_lsb_written |=> freq_apply_r
    ##0 applied_freq_r == $past(carrier_freq_word)) else $error("retune missed");
  temp_capture_a: assert property (radio_evt.cal_done |=> last_temp_r == $past(temp_reading))
    else $error("temp not captured");
  boost_max_a: assert property (amp_r[2:0] == AMP_MAX && output_level == LEVEL_MAX |=> boost_max_r)
    else $error("boost max missing");

endmodule : radio_status_io_registers
`default_nettype wire
